/* File: verilog/irdp_pkg.sv */
// package: register map, field layout and types of the indirect ram data port
package irdp_pkg;
  // -------------------------------------------------
  // register map
  // -------------------------------------------------
  localparam logic [7:0] OFF_SELECT = 8'h24;
  localparam logic [7:0] OFF_COMMAND = 8'h28;
  localparam logic [7:0] OFF_ADDRESS = 8'h2c;
  localparam logic [7:0] OFF_DATA = 8'h30;
  // -------------------------------------------------
  // fields and resets
  // -------------------------------------------------
  localparam int READY_BIT = 31;
  localparam int TARGET_W = 4;
  localparam int RAM_ADDR_W = 14;
  localparam logic [3:0] TARGET_RESET = 4'h0;
  localparam logic [13:0] ADDRESS_RESET = 14'h0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic READY_RESET = 1'b1;
  localparam logic WRITE_RESET = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // ram access latency in clock cycles, arbitrary plain default
  localparam logic [3:0] RAM_LATENCY = 4'h2;
  localparam logic [3:0] COUNT_ONE = 4'h1;

  typedef enum logic [3:0] {
    TGT_RECEIVE_BUFFER = 4'h0,
    TGT_VLAN_HASH_TABLE = 4'h1,
    TGT_SEGMENTATION_HEADER = 4'h2,
    TGT_RX_FIFO_CONTROL = 4'h3,
    TGT_TX_FIFO_CONTROL = 4'h4,
    TGT_DESCRIPTOR = 4'h5,
    TGT_TRANSMIT_BUFFER = 4'h7
  } irdp_target_e;

  // request toward the internal rams
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] target;
    logic [13:0] address;
    logic [31:0] wdata;
  } irdp_ram_req_s;

  // answer from the internal rams
  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } irdp_ram_rsp_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } irdp_apb_req_s;
endpackage

/* File: verilog/irdp_access_seq.sv */
// sequencer for one indirect ram access: busy window, latency count, read capture
module irdp_access_seq (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic start,
  input wire logic write,
  input wire logic [31:0] ramReadData,
  output logic ready,
  output logic ramStrobe,
  output logic captureValid,
  output logic [31:0] captureData
);
  import irdp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } irdp_seq_e;

  irdp_seq_e state;
  irdp_seq_e next_state;
  logic [3:0] count;
  logic [3:0] next_count;
  logic isWrite;
  logic next_isWrite;

  // -------------------------------------------------
  // next state
  // -------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    next_isWrite = isWrite;
    unique case (state)
      ST_IDLE: begin
        if (start) begin // R5 R10
          next_state = ST_WAIT;
          next_count = RAM_LATENCY;
          next_isWrite = write;
        end
      end
      ST_WAIT: begin
        next_count = count - COUNT_ONE;
        if (count == COUNT_ONE) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= 4'h0;
      isWrite <= WRITE_RESET;
    end else if (clockEnable) begin
      state <= next_state;
      count <= next_count;
      isWrite <= next_isWrite;
    end
  end

  // ready only after the read word is captured: done state loads data, idle reports ready
  assign ready = (state == ST_IDLE); // R1 R2 R10
  assign ramStrobe = (state == ST_WAIT) && (count == RAM_LATENCY);
  assign captureValid = (state == ST_DONE) && !isWrite; // R2 R8
  assign captureData = ramReadData;
endmodule

/* File: verilog/irdp_top.sv */
// top of the indirect ram data port: apb register slave and ram request port
// Operation
// R1: select bit 31 is read-only ready, 1 idle, 0 busy, resets to 1.
// R2: on a read, ready returns only after the word sits in data register.
// R3: select bits 3:0 pick the ram, reset zero, listed codes, rest reserved.
// R4: software touches only the vlan hash table while running.
// R5: a command write while ready starts one access; bit 0 one writes, zero reads.
// R6: software loads target, address and write data before the command.
// R7: address register holds 14-bit word address, resets zero, upper bits zero.
// R8: data register supplies write word and receives read word, resets zero.
// R9: software waits for ready before taking read data.
// R10: ready clears the cycle after command; command writes while busy ignored.
//
// The APB register port was decided locally.
module irdp_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output irdp_pkg::irdp_ram_req_s ramReq,
  input wire irdp_pkg::irdp_ram_rsp_s ramRsp
);
  import irdp_pkg::*;

  logic [3:0] target;
  logic [3:0] next_target;
  logic cmdWrite;
  logic next_cmdWrite;
  logic [13:0] ramAddress;
  logic [13:0] next_ramAddress;
  logic [31:0] dataWord;
  logic [31:0] next_dataWord;
  logic [31:0] readWord;
  logic [31:0] next_readWord;
  logic portReadyFlag;
  logic ramStrobe;
  logic captureValid;
  logic [31:0] captureData;
  logic access;
  logic wrAccess;
  logic mapped;
  logic startCmd;

  // -------------------------------------------------
  // bus decode
  // -------------------------------------------------
  // zero wait states; unmapped addresses answer pslverr and read zero
  assign access = psel && penable;
  assign wrAccess = access && pwrite;
  assign mapped = (paddr == OFF_SELECT) || (paddr == OFF_COMMAND) ||
                  (paddr == OFF_ADDRESS) || (paddr == OFF_DATA);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  // busy-time command writes are dropped so the running access keeps its operands
  assign startCmd = wrAccess && (paddr == OFF_COMMAND) && portReadyFlag; // R5 R10

  // -------------------------------------------------
  // register next values
  // -------------------------------------------------
  always_comb begin
    next_target = target;
    next_cmdWrite = cmdWrite;
    next_ramAddress = ramAddress;
    next_dataWord = dataWord;
    next_readWord = ZERO_WORD;
    if (wrAccess && (paddr == OFF_SELECT)) begin
      next_target = pwdata[TARGET_W-1:0]; // R3
    end
    if (startCmd) begin
      next_cmdWrite = pwdata[0]; // R5
    end
    if (wrAccess && (paddr == OFF_ADDRESS)) begin
      next_ramAddress = pwdata[RAM_ADDR_W-1:0]; // R7
    end
    if (wrAccess && (paddr == OFF_DATA)) begin
      next_dataWord = pwdata; // R8
    end
    // a read result lands in the data register on the same edge that ready returns
    if (captureValid) begin
      next_dataWord = captureData; // R2 R8
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_SELECT: begin
          next_readWord = ZERO_WORD;
          next_readWord[READY_BIT] = portReadyFlag; // R1
          next_readWord[TARGET_W-1:0] = target;
        end
        OFF_COMMAND: next_readWord = {31'h0, cmdWrite};
        OFF_ADDRESS: next_readWord = {18'h0, ramAddress}; // R7
        OFF_DATA: next_readWord = captureValid ? captureData : dataWord;
        default: next_readWord = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      target <= TARGET_RESET;
      cmdWrite <= WRITE_RESET;
      ramAddress <= ADDRESS_RESET;
      dataWord <= DATA_RESET;
      readWord <= ZERO_WORD;
    end else if (clockEnable) begin
      target <= next_target;
      cmdWrite <= next_cmdWrite;
      ramAddress <= next_ramAddress;
      dataWord <= next_dataWord;
      readWord <= next_readWord;
    end
  end

  assign prdata = readWord;

  // -------------------------------------------------
  // access sequencer
  // -------------------------------------------------
  irdp_access_seq u_seq (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .start(startCmd),
    .write(pwdata[0]),
    .ramReadData(ramRsp.rdata),
    .ready(portReadyFlag),
    .ramStrobe(ramStrobe),
    .captureValid(captureValid),
    .captureData(captureData)
  );

  always_comb begin
    ramReq.valid = ramStrobe;
    ramReq.write = cmdWrite;
    ramReq.target = target;
    ramReq.address = ramAddress;
    ramReq.wdata = dataWord;
  end

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  property p_ready_reset;
    @(posedge clock) $fell(rst) |-> portReadyFlag;
  endproperty
  a_ready_reset: assert property (p_ready_reset) else $error("ready not set after reset"); // R1

  property p_busy_after_cmd;
    @(posedge clock) disable iff (rst) startCmd && clockEnable |=> !portReadyFlag;
  endproperty
  a_busy_after_cmd: assert property (p_busy_after_cmd) else $error("ready stayed set after command"); // R10

  property p_read_data_before_ready;
    @(posedge clock) disable iff (rst)
      $rose(portReadyFlag) && !cmdWrite |-> dataWord == $past(ramRsp.rdata);
  endproperty
  a_read_data_before_ready: assert property (p_read_data_before_ready) else $error("ready before read data"); // R2

  property p_cmd_bit;
    @(posedge clock) disable iff (rst) startCmd && clockEnable |=> cmdWrite == $past(pwdata[0]);
  endproperty
  a_cmd_bit: assert property (p_cmd_bit) else $error("command bit not stored"); // R5

  property p_strobe_one;
    @(posedge clock) disable iff (rst) startCmd && clockEnable |=> ramStrobe ##1 !ramStrobe;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("ram strobe not single"); // R5

  property p_ready_returns;
    @(posedge clock) disable iff (rst) startCmd && clockEnable ##1 clockEnable [*4] |-> portReadyFlag;
  endproperty
  a_ready_returns: assert property (p_ready_returns) else $error("ready did not return"); // R10

  property p_target_write;
    @(posedge clock) disable iff (rst)
      wrAccess && paddr == OFF_SELECT && clockEnable |=> target == $past(pwdata[3:0]);
  endproperty
  a_target_write: assert property (p_target_write) else $error("target not stored"); // R3

  property p_addr_upper_zero;
    @(posedge clock) disable iff (rst)
      psel && !penable && !pwrite && paddr == OFF_ADDRESS && clockEnable |=> prdata[31:14] == 18'h0;
  endproperty
  a_addr_upper_zero: assert property (p_addr_upper_zero) else $error("address upper bits nonzero"); // R7

  property p_select_read;
    @(posedge clock) disable iff (rst)
      psel && !penable && !pwrite && paddr == OFF_SELECT && clockEnable |=> prdata[31] == $past(portReadyFlag);
  endproperty
  a_select_read: assert property (p_select_read) else $error("ready bit misread"); // R1

  property p_select_reserved;
    @(posedge clock) disable iff (rst)
      psel && !penable && !pwrite && paddr == OFF_SELECT && clockEnable |=> prdata[READY_BIT-1:TARGET_W] == '0;
  endproperty
  a_select_reserved: assert property (p_select_reserved) else $error("select reserved bits nonzero"); // R1

  // a busy-time command must leave the running access and its direction alone
  property p_busy_cmd_dropped;
    @(posedge clock) disable iff (rst)
      wrAccess && paddr == OFF_COMMAND && !portReadyFlag && clockEnable |=> cmdWrite == $past(cmdWrite);
  endproperty
  a_busy_cmd_dropped: assert property (p_busy_cmd_dropped) else $error("command taken while busy"); // R10

  property p_address_write;
    @(posedge clock) disable iff (rst)
      wrAccess && paddr == OFF_ADDRESS && clockEnable |=> ramAddress == $past(pwdata[RAM_ADDR_W-1:0]);
  endproperty
  a_address_write: assert property (p_address_write) else $error("address not stored"); // R7

  property p_data_write;
    @(posedge clock) disable iff (rst)
      wrAccess && paddr == OFF_DATA && !captureValid && clockEnable |=> dataWord == $past(pwdata);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data word not stored"); // R8

  property p_strobe_busy;
    @(posedge clock) disable iff (rst) ramStrobe |-> !portReadyFlag;
  endproperty
  a_strobe_busy: assert property (p_strobe_busy) else $error("ram strobe while ready"); // R5

  // clock enable low must hold the data word, address and target registers, the ready flag included
  property p_freeze;
    @(posedge clock) disable iff (rst)
      !clockEnable |=> $stable(dataWord) && $stable(ramAddress) && $stable(target) && $stable(portReadyFlag);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R8
endmodule

/* File: dv/irdp_top_tb.sv */
// testbench: apb register tests of the indirect ram data port
module irdp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irdp_pkg::*;

  // -------------------------------------------------
  // signals
  // -------------------------------------------------
  localparam logic [3:0] TGTS [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'hb};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clockEnable = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  irdp_ram_req_s ramReq;
  irdp_ram_rsp_s ramRsp = '0;
  irdp_ram_req_s seenReq;
  int nPulse = 0;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic err;
  int p0;

  initial begin
    forever begin
      #2.5;
      clock = ~clock;
    end
  end

  irdp_top dut_u (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ramReq(ramReq),
    .ramRsp(ramRsp)
  );

  // pre-edge values are seen here, so a one-cycle pulse is never missed
  always @(posedge clock) begin
    if (ramReq.valid === 1'b1) begin
      nPulse <= nPulse + 1;
      seenReq <= ramReq;
    end
  end

  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    rdr(OFF_SELECT);
    while (rd[READY_BIT] !== 1'b1 && k < 20) begin
      rdr(OFF_SELECT);
      k++;
    end
    check({31'h0, rd[READY_BIT]}, 32'h1);
  endtask

  // one complete access; the ram answers with the halves of d swapped
  task automatic access(input logic [3:0] tgt, input logic [13:0] adr, input logic w, input logic [31:0] d);
    wr(OFF_SELECT, {28'h0, tgt});
    wr(OFF_ADDRESS, {18'h0, adr});
    wr(OFF_DATA, d);
    ramRsp.rdata <= {d[15:0], d[31:16]};
    p0 = nPulse;
    wr(OFF_COMMAND, {31'h0, w});
    rdr(OFF_SELECT);
    check({31'h0, rd[READY_BIT]}, 32'h0);
    wait_ready();
    check(32'(nPulse - p0), 32'h1);
    check({31'h0, seenReq.write}, {31'h0, w});
    check({28'h0, seenReq.target}, {28'h0, tgt});
    check({18'h0, seenReq.address}, {18'h0, adr});
    check(seenReq.wdata, d);
    rdr(OFF_DATA);
    check(rd, w ? d : {d[15:0], d[31:16]});
    // stale read data must not be relied on once the access is over
    ramRsp.rdata <= ~ramRsp.rdata;
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // -------------------------------------------------
  // tests
  // -------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rdr(OFF_SELECT);
    check(rd, 32'h8000_0000);
    rdr(OFF_COMMAND);
    check(rd, 32'h0000_0000);
    rdr(OFF_ADDRESS);
    check(rd, 32'h0000_0000);
    rdr(OFF_DATA);
    check(rd, 32'h0000_0000);
    wr(OFF_ADDRESS, 32'hffff_ffff);
    rdr(OFF_ADDRESS);
    check(rd, 32'h0000_3fff);
    wr(OFF_SELECT, 32'h7fff_fffa);
    rdr(OFF_SELECT);
    check(rd, 32'h8000_000a);
    wr(8'h40, 32'h1234_5678);
    rdr(8'h40);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      access(TGTS[i], (i % 2 == 1) ? 14'h3fff : 14'h0000, 1'b1, 32'ha5c3_0000 | i);
      access(TGTS[i], 14'h1555 + 14'(i), 1'b0, 32'h5a3c_8000 | i);
    end
    // run-time style access: only the hash table is touched
    access(TGT_VLAN_HASH_TABLE, 14'h0abc, 1'b0, 32'h0f1e_2d3c);
    // a second command while busy must be dropped
    p0 = nPulse;
    wr(OFF_COMMAND, 32'h0000_0001);
    wr(OFF_COMMAND, 32'h0000_0000);
    wait_ready();
    check(32'(nPulse - p0), 32'h1);
    rdr(OFF_COMMAND);
    check(rd, 32'h0000_0001);
    // frozen clock enable: the command write is not taken
    p0 = nPulse;
    clockEnable <= 1'b0;
    wr(OFF_COMMAND, 32'h0000_0000);
    clockEnable <= 1'b1;
    repeat (6) @(posedge clock);
    check(32'(nPulse - p0), 32'h0);
    rdr(OFF_COMMAND);
    check(rd, 32'h0000_0001);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdr(OFF_SELECT);
    check(rd, 32'h8000_0000);
    rdr(OFF_DATA);
    check(rd, 32'h0000_0000);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
endmodule
